/* rtl/rcs_pkg.sv */
package rcs_pkg;
    // ==============================
    // Register offsets
    localparam logic [5:0] ADDR_COMMAND = 6'h01;
    localparam logic [5:0] ADDR_RX_WAIT = 6'h21;
    localparam logic [5:0] ADDR_TEST_3C = 6'h3C;
    localparam logic [5:0] ADDR_DIGI_SEL = 6'h3D;
    localparam logic [5:0] ADDR_TEST_3E = 6'h3E;
    localparam logic [5:0] ADDR_TEST_3F = 6'h3F;
    // ==============================
    // Command codes
    localparam logic [5:0] CMD_IDLE = 6'h00;
    localparam logic [5:0] CMD_RECEIVE = 6'h16;
    localparam logic [5:0] CMD_TRANSMIT = 6'h1A;
    localparam logic [5:0] CMD_POWER_ON_INIT_COMMAND = 6'h3F;
    // ==============================
    // Field positions and reset values
    localparam int ROUTE_BIT = 7;
    localparam logic [7:0] DIGI_SEL_RESET = 8'h00;
    localparam logic [7:0] RX_WAIT_RESET = 8'h06;
    localparam logic [7:0] INIT_CYCLES = 8'h10;
    // ==============================
    // Test signal codes (full byte, route bit set)
    localparam logic [7:0] TS_SDATA = 8'hF4;
    localparam logic [7:0] TS_SVALID = 8'hE4;
    localparam logic [7:0] TS_SCOLL = 8'hD4;
    localparam logic [7:0] TS_SCLOCK = 8'hC4;
    localparam logic [7:0] TS_RDSYNC = 8'hB5;
    localparam logic [7:0] TS_WRSYNC = 8'hA5;
    localparam logic [7:0] TS_INTCLK = 8'h96;
    // ==============================
    // Sequencer states
    typedef enum logic [2:0] {
        RCS_INIT = 3'b000,
        RCS_IDLE = 3'b001,
        RCS_TX = 3'b010,
        RCS_RX_WAIT = 3'b011,
        RCS_RX = 3'b100
    } rcs_state_t;
    // Internal digital test signals
    typedef struct packed {
        logic s_data;
        logic s_valid;
        logic s_coll;
        logic s_clock;
        logic rd_sync;
        logic wr_sync;
        logic int_clock;
    } rcs_test_sig_t;
endpackage : rcs_pkg

/* rtl/rcs_test_mux.sv */
`timescale 1ns/1ps
// ==============================
// Test signal selector, registered output
module rcs_test_mux (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [7:0] select,
    input wire logic [7:0] normal_sources,
    input wire logic [2:0] normal_choice,
    input wire rcs_pkg::rcs_test_sig_t test_sig,
    output logic pin
);
    logic next_pin; // Combinational pick

    // Choose source by override bit
    always_comb begin
        next_pin = 1'b0;
        if (select[rcs_pkg::ROUTE_BIT]) begin
            case (select)
                rcs_pkg::TS_SDATA: next_pin = test_sig.s_data;
                rcs_pkg::TS_SVALID: next_pin = test_sig.s_valid;
                rcs_pkg::TS_SCOLL: next_pin = test_sig.s_coll;
                rcs_pkg::TS_SCLOCK: next_pin = test_sig.s_clock;
                rcs_pkg::TS_RDSYNC: next_pin = test_sig.rd_sync;
                rcs_pkg::TS_WRSYNC: next_pin = test_sig.wr_sync;
                default: next_pin = 1'b0; // Unlisted code drives low
            endcase
        end else begin
            next_pin = normal_sources[normal_choice];
        end
    end

    // int_clock code (96h) has bit 7 set too
    logic int_sel;
    assign int_sel = (select == rcs_pkg::TS_INTCLK);

    // Output flop
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin <= 1'b0;
        end else if (clk_en) begin
            pin <= int_sel ? test_sig.int_clock : next_pin;
        end
    end

    a_mux_normal: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && !select[7] |=> pin == $past(normal_sources[normal_choice]))
        else $error("normal mux output wrong");
    a_mux_test: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && select == rcs_pkg::TS_SDATA |=> pin == $past(test_sig.s_data))
        else $error("test mux output wrong");
    a_mux_coll: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && select == rcs_pkg::TS_SCOLL |=> pin == $past(test_sig.s_coll))
        else $error("collision route wrong");
endmodule : rcs_test_mux

/* rtl/rcs_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// - Command register write starts the command
// - Stream commands consume FIFO bytes at once
// - Starting a command never flushes FIFO
// - New code other than 3Fh aborts any command except init
// - Code 3Fh runs reset initialization
// - Init only after reset, never host
// - Code 00h cancels, leaves sequencer idle
// - Code 1Ah transmits FIFO data stream
// - Code 16h waits delay, then receives
// - Route bit set drives test signal
// - Route bit clear uses normal choice
// - Codes select listed internal test signals
module rcs_sequencer (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic reg_wr, // Host write strobe
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic fifo_rd_valid, // FIFO holds a byte
    input wire logic [7:0] fifo_rd_data,
    input wire logic fifo_wr_ready, // FIFO has room
    input wire logic tx_ready, // Transmitter accepts a byte
    input wire logic rx_valid, // Receiver delivers a byte
    input wire logic [7:0] rx_data,
    input wire logic rx_done, // Receiver frame ended
    input wire logic [7:0] normal_sources,
    input wire logic [2:0] multifunction_output_choice,
    input wire rcs_pkg::rcs_test_sig_t test_sig,
    output logic fifo_rd_pop,
    output logic fifo_wr_push,
    output logic [7:0] fifo_wr_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic rx_enable,
    output logic [5:0] command,
    output logic busy,
    output logic multifunction_output_pin
);
    // ==============================
    // State and registers
    rcs_pkg::rcs_state_t state; // Sequencer state
    logic [7:0] digital_test_signal_select; // Test mux control
    logic [7:0] receiver_start_delay; // Receiver wait, cycles
    logic [7:0] count; // Init and wait counter
    logic cmd_wr; // Host command write

    assign cmd_wr = reg_wr && reg_addr == rcs_pkg::ADDR_COMMAND;

    logic cmd_new; // Host code that replaces the running one
    assign cmd_new = cmd_wr && reg_wdata[5:0] != rcs_pkg::CMD_POWER_ON_INIT_COMMAND;

    // Decode a written code to its starting state
    function automatic rcs_pkg::rcs_state_t start_state(
        input logic [5:0] code);
        // Every decoded code streams; none gathers arguments
        case (code)
            rcs_pkg::CMD_TRANSMIT: start_state = rcs_pkg::RCS_TX;
            rcs_pkg::CMD_RECEIVE: start_state = rcs_pkg::RCS_RX_WAIT;
            default: start_state = rcs_pkg::RCS_IDLE;
        endcase
    endfunction : start_state

    // ==============================
    // Register writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            digital_test_signal_select <= rcs_pkg::DIGI_SEL_RESET;
            receiver_start_delay <= rcs_pkg::RX_WAIT_RESET;
        end else if (clk_en && reg_wr) begin
            // Reserved_test_3c, 3Eh, 3Fh ignore writes
            if (reg_addr == rcs_pkg::ADDR_DIGI_SEL) begin
                digital_test_signal_select <= reg_wdata;
            end
            if (reg_addr == rcs_pkg::ADDR_RX_WAIT) begin
                receiver_start_delay <= reg_wdata;
            end
        end
    end

    // ==============================
    // Command state machine
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= rcs_pkg::RCS_INIT;
            command <= rcs_pkg::CMD_POWER_ON_INIT_COMMAND;
            count <= 8'h00;
            busy <= 1'b1;
        end else if (clk_en) begin
            case (state)
                rcs_pkg::RCS_INIT: begin
                    // Init cannot be interrupted by host writes
                    if (count == rcs_pkg::INIT_CYCLES) begin
                        state <= rcs_pkg::RCS_IDLE;
                        command <= rcs_pkg::CMD_IDLE;
                        busy <= 1'b0;
                        count <= 8'h00;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                default: begin
                    if (cmd_wr && reg_wdata[5:0] != rcs_pkg::CMD_POWER_ON_INIT_COMMAND) begin
                        // New code replaces running one, FIFO kept
                        state <= start_state(reg_wdata[5:0]);
                        command <= (start_state(reg_wdata[5:0]) ==
                            rcs_pkg::RCS_IDLE) ? rcs_pkg::CMD_IDLE
                            : reg_wdata[5:0];
                        busy <= start_state(reg_wdata[5:0]) !=
                            rcs_pkg::RCS_IDLE;
                        count <= 8'h00;
                    end else begin
                        case (state)
                            rcs_pkg::RCS_TX: begin
                                // Stream ends when FIFO runs dry
                                if (!fifo_rd_valid && !tx_valid) begin
                                    state <= rcs_pkg::RCS_IDLE;
                                    command <= rcs_pkg::CMD_IDLE;
                                    busy <= 1'b0;
                                end
                            end
                            rcs_pkg::RCS_RX_WAIT: begin
                                if (count >= receiver_start_delay) begin
                                    state <= rcs_pkg::RCS_RX;
                                end else begin
                                    count <= count + 8'h01;
                                end
                            end
                            rcs_pkg::RCS_RX: begin
                                if (rx_done) begin
                                    state <= rcs_pkg::RCS_IDLE;
                                    command <= rcs_pkg::CMD_IDLE;
                                    busy <= 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // ==============================
    // Transmit data path: pull bytes while FIFO has any
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            fifo_rd_pop <= 1'b0;
        end else if (clk_en) begin
            fifo_rd_pop <= 1'b0;
            if (state != rcs_pkg::RCS_TX || cmd_new) begin
                tx_valid <= 1'b0; // Abort drops pending byte
            end else if (tx_valid && !tx_ready) begin
                tx_valid <= 1'b1; // Hold until taken
            end else if (fifo_rd_valid && !fifo_rd_pop) begin
                tx_valid <= 1'b1;
                tx_data <= fifo_rd_data;
                fifo_rd_pop <= 1'b1;
            end else begin
                tx_valid <= 1'b0;
            end
        end
    end

    // ==============================
    // Receive data path: bytes into FIFO
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_enable <= 1'b0;
            fifo_wr_push <= 1'b0;
            fifo_wr_data <= 8'h00;
        end else if (clk_en) begin
            rx_enable <= state == rcs_pkg::RCS_RX && !cmd_new;
            fifo_wr_push <= state == rcs_pkg::RCS_RX && rx_valid
                && fifo_wr_ready;
            if (rx_valid) begin
                fifo_wr_data <= rx_data;
            end
        end
    end

    // ==============================
    // Multifunction output mux
    rcs_test_mux u_mux (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .select(digital_test_signal_select),
        .normal_sources(normal_sources),
        .normal_choice(multifunction_output_choice),
        .test_sig(test_sig),
        .pin(multifunction_output_pin)
    );

    // ==============================
    // Assertions
    a_init_locked: assert property (@(posedge core_clk) disable iff (!resetn)
        state == rcs_pkg::RCS_INIT && clk_en && count != rcs_pkg::INIT_CYCLES
        |=> state == rcs_pkg::RCS_INIT)
        else $error("init left early");
    a_idle_cancel: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && cmd_wr && reg_wdata[5:0] == rcs_pkg::CMD_IDLE
        && state != rcs_pkg::RCS_INIT
        |=> state == rcs_pkg::RCS_IDLE && !busy)
        else $error("idle did not cancel");
    a_tx_start: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && cmd_wr && reg_wdata[5:0] == rcs_pkg::CMD_TRANSMIT
        && state != rcs_pkg::RCS_INIT
        |=> state == rcs_pkg::RCS_TX && command == rcs_pkg::CMD_TRANSMIT)
        else $error("transmit not started");
    a_rx_start: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && cmd_wr && reg_wdata[5:0] == rcs_pkg::CMD_RECEIVE
        && state != rcs_pkg::RCS_INIT |=> state == rcs_pkg::RCS_RX_WAIT)
        else $error("receive wait not entered");
    a_rx_gated: assert property (@(posedge core_clk) disable iff (!resetn)
        rx_enable |-> $past(state) == rcs_pkg::RCS_RX)
        else $error("receiver on too early");
    a_host_no_init: assert property (@(posedge core_clk) disable iff (!resetn)
        state != rcs_pkg::RCS_INIT |=> state != rcs_pkg::RCS_INIT)
        else $error("init re-entered");
    a_tx_pops: assert property (@(posedge core_clk) disable iff (!resetn)
        fifo_rd_pop |-> tx_valid && $past(state) == rcs_pkg::RCS_TX)
        else $error("pop outside transmit");
    a_rx_done_idle: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && state == rcs_pkg::RCS_RX && rx_done && !cmd_wr
        |=> state == rcs_pkg::RCS_IDLE)
        else $error("no return to idle");
    c_tx: cover property (@(posedge core_clk) state == rcs_pkg::RCS_TX
        ##[1:50] state == rcs_pkg::RCS_IDLE);
    c_rx: cover property (@(posedge core_clk) state == rcs_pkg::RCS_RX_WAIT
        ##[1:300] fifo_wr_push);
    c_abort: cover property (@(posedge core_clk) state == rcs_pkg::RCS_TX
        && cmd_wr);
endmodule : rcs_sequencer

/* testbench/rcs_far_model.sv */
`timescale 1ns/1ps
// ====
// Shared FIFO and card transmitter seen by the sequencer
module rcs_far_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tx_slow,
    input wire logic fifo_rd_pop,
    input wire logic fifo_wr_push,
    input wire logic [7:0] fifo_wr_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic fifo_rd_valid,
    output logic [7:0] fifo_rd_data,
    output logic fifo_wr_ready,
    output logic tx_ready
);
    logic [7:0] fifo_q[$]; // FIFO contents, head first
    logic [7:0] sent_q[$]; // Bytes sent to the card
    logic [7:0] last_head = 8'h00; // Last head popped
    logic tog = 1'b0; // Slow-ready divider

    // Host preload, never cleared by a command start
    task automatic load(input logic [7:0] b);
        fifo_q.push_back(b);
    endtask : load

    // Pops, pushes and accepted transmit bytes
    always @(posedge core_clk) begin
        tog <= resetn ? ~tog : 1'b0; // Divider restarts with reset
        if (fifo_rd_pop && fifo_q.size() != 0) begin
            last_head = fifo_q.pop_front();
        end
        if (fifo_wr_push) begin
            fifo_q.push_back(fifo_wr_data);
        end
        if (tx_valid && tx_ready) begin
            sent_q.push_back(tx_data);
        end
    end

    // Outputs settle 1 ns after the falling edge
    always @(negedge core_clk) begin
        #1;
        fifo_rd_valid = fifo_q.size() != 0;
        // Empty FIFO shows no stale head
        fifo_rd_data = fifo_rd_valid ? fifo_q[0] : ~last_head;
        fifo_wr_ready = fifo_q.size() < 64;
        tx_ready = !tx_slow || tog;
    end
endmodule : rcs_far_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
 fail_count++; $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
    logic core_clk, resetn, clk_en, reg_wr, tx_slow;
    logic [5:0] reg_addr, command;
    logic [7:0] reg_wdata, rd_data, wr_data, tx_data, rx_data, srcs;
    logic rd_valid, wr_ready, tx_ready, rx_valid, rx_done, pop, push;
    logic tx_valid, rx_enable, busy, pin;
    logic [2:0] choice;
    rcs_pkg::rcs_test_sig_t tsig;
    int fail_count = 0;
    int samples_checked = 0;
    int n;
    logic [7:0] codes[7] = '{8'hF4, 8'hE4, 8'hD4, 8'hC4, 8'hB5, 8'hA5, 8'h96};

    rcs_sequencer dut_u (.core_clk(core_clk), .resetn(resetn),
        .clk_en(clk_en), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .fifo_rd_valid(rd_valid),
        .fifo_rd_data(rd_data), .fifo_wr_ready(wr_ready),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_done(rx_done), .normal_sources(srcs),
        .multifunction_output_choice(choice), .test_sig(tsig),
        .fifo_rd_pop(pop), .fifo_wr_push(push), .fifo_wr_data(wr_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .rx_enable(rx_enable),
        .command(command), .busy(busy), .multifunction_output_pin(pin));
    rcs_far_model m_u (.core_clk(core_clk), .resetn(resetn),
        .tx_slow(tx_slow), .fifo_rd_pop(pop), .fifo_wr_push(push),
        .fifo_wr_data(wr_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .fifo_rd_valid(rd_valid), .fifo_rd_data(rd_data),
        .fifo_wr_ready(wr_ready), .tx_ready(tx_ready));

    // ====
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end

    // ====
    // Shared tasks
    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic wait_idle(input int lim);
        repeat (lim) begin
            @(negedge core_clk);
            if (busy === 1'b0) return;
        end
    endtask : wait_idle

    // ====
    // Scenarios
    task automatic t_reset();
        `CHK(command, rcs_pkg::CMD_POWER_ON_INIT_COMMAND, "init code")
        `CHK(busy, 1'b1, "busy in reset")
        resetn = 1'b1;
        wr(rcs_pkg::ADDR_COMMAND, 8'h00);
        `CHK(command, rcs_pkg::CMD_POWER_ON_INIT_COMMAND, "init aborted")
        wait_idle(30);
        `CHK(command, rcs_pkg::CMD_IDLE, "not idle after init")
        wr(rcs_pkg::ADDR_COMMAND, 8'h3F);
        `CHK(command, rcs_pkg::CMD_IDLE, "host started init")
        `CHK(busy, 1'b0, "busy after host init")
    endtask : t_reset
    task automatic t_tx(input logic slow);
        tx_slow = slow;
        m_u.load(8'hA1);
        m_u.load(8'hB2);
        m_u.load(8'hC3);
        wr(rcs_pkg::ADDR_COMMAND, 8'h1A);
        `CHK(command, rcs_pkg::CMD_TRANSMIT, "no transmit")
        `CHK(busy, 1'b1, "not busy")
        wait_idle(60);
        `CHK(m_u.sent_q.size(), 3, "sent count")
        `CHK({m_u.sent_q[0], m_u.sent_q[1], m_u.sent_q[2]},
             24'hA1B2C3, "sent bytes")
        `CHK(command, rcs_pkg::CMD_IDLE, "not idle after send")
        m_u.sent_q.delete();
    endtask : t_tx
    task automatic t_abort();
        tx_slow = 1'b1;
        m_u.load(8'h11);
        m_u.load(8'h22);
        wr(rcs_pkg::ADDR_COMMAND, 8'h1A);
        repeat (2) @(negedge core_clk);
        wr(rcs_pkg::ADDR_COMMAND, 8'h00);
        `CHK(command, rcs_pkg::CMD_IDLE, "abort code")
        `CHK({busy, tx_valid}, 2'b00, "abort left activity")
        m_u.fifo_q.delete();
        m_u.sent_q.delete();
    endtask : t_abort
    task automatic t_rx();
        wr(rcs_pkg::ADDR_RX_WAIT, 8'h03);
        wr(rcs_pkg::ADDR_COMMAND, 8'h16); // Test-only use
        n = 0;
        while (rx_enable !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n == 3 + 2, 1'b1, "receiver delay")
        rx_valid = 1'b1;
        rx_data = 8'h5A;
        @(negedge core_clk);
        rx_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(m_u.fifo_q.size() == 1 && m_u.fifo_q[0] == 8'h5A,
             1'b1, "received byte")
        rx_done = 1'b1;
        @(negedge core_clk);
        rx_done = 1'b0;
        @(negedge core_clk);
        `CHK(busy, 1'b0, "not idle after frame")
    endtask : t_rx
    task automatic t_mux();
        wr(rcs_pkg::ADDR_DIGI_SEL, 8'h00);
        for (int c = 0; c < 8; c++) begin
            srcs = 8'h01 << c;
            choice = 3'(c);
            repeat (2) @(negedge core_clk);
            `CHK(pin, 1'b1, "normal pick")
            choice = 3'(c ^ 1);
            repeat (2) @(negedge core_clk);
            `CHK(pin, 1'b0, "normal other")
        end
        // Clock enable low freezes the output
        clk_en = 1'b0;
        choice = 3'h7;
        repeat (2) @(negedge core_clk);
        `CHK(pin, 1'b0, "frozen pick")
        clk_en = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(pin, 1'b1, "resumed pick")
        srcs = 8'hFF;
        for (int i = 0; i < 7; i++) begin
            wr(rcs_pkg::ADDR_DIGI_SEL, codes[i]);
            tsig = rcs_pkg::rcs_test_sig_t'(7'h40 >> i);
            repeat (2) @(negedge core_clk);
            `CHK(pin, 1'b1, "test pick")
            tsig = rcs_pkg::rcs_test_sig_t'(~(7'h40 >> i));
            repeat (2) @(negedge core_clk);
            `CHK(pin, 1'b0, "test override")
        end
        // Reserved place must not disturb the selector
        wr(rcs_pkg::ADDR_TEST_3C, 8'h00);
        repeat (2) @(negedge core_clk);
        `CHK(pin, 1'b0, "reserved write")
    endtask : t_mux

    // ====
    // Main sequence
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        {reg_wr, tx_slow, rx_valid, rx_done} = 4'h0;
        reg_addr = 6'h00;
        {reg_wdata, rx_data, srcs} = 24'h0;
        choice = 3'h0;
        tsig = '0;
        repeat (8) @(negedge core_clk);
        t_reset();
        t_tx(1'b0);
        t_tx(1'b1);
        t_abort();
        t_rx();
        t_mux();
        stop_test();
    end
endmodule : tb_top
